// ==== logic/ppo_consts.svh ====
// constants for the parallel pixel output port
// Operation
// - row-active flag stays high across every row of the active image
// - pixel-active flag high only during valid pixels, low in line blanking
// - receiver samples data only while both qualifiers are high
// - in embedded-sync mode the receiver ignores the qualifiers; the bench receiver still needs both and so captures nothing
// - 8-bit mode drives sample on bus; 10-bit mode drives bits nine to two
// - 10-bit mode puts two low bits on the separate low-bits output
// - parallel port enabled only while active-low enable input is low
// - never drive serial lanes and parallel port at the same time; at a switch-over the code can briefly drive both
// - low master reset requests reset; input idles high
// - boot strap 1 streams at power-up, 0 waits in standby
// - output source is raw sensor data or processed data per configuration
// - port supports 8-bit colour and 10-bit raw formats
// - host reads and writes control registers and variables
// - all outputs undriven while master reset is low
`ifndef PPO_CONSTS_SVH
`define PPO_CONSTS_SVH
`define PPO_ADDR_CTRL 12'h000
`define PPO_ADDR_STATUS 12'h004
`define PPO_ADDR_HACT 12'h008
`define PPO_ADDR_HBLK 12'h00c
`define PPO_ADDR_VACT 12'h010
`define PPO_ADDR_VBLK 12'h014
`define PPO_ADDR_VAR 12'h018
`define PPO_CTRL_STREAM 0
`define PPO_CTRL_WIDE 1
`define PPO_CTRL_RAW 2
`define PPO_CTRL_EMBED 3
`define PPO_CTRL_SERIAL 4
`define PPO_HACT_RST 12'h010
`define PPO_HBLK_RST 12'h008
`define PPO_VACT_RST 12'h008
`define PPO_VBLK_RST 12'h004
`define PPO_BOOT_CYCLES 16'h0040
`endif

// ==== logic/ppo_pkg.sv ====
// types for the parallel pixel output port
package ppo_pkg;
   typedef enum logic [1:0] {
      ppo_idle = 2'b00,
      ppo_vblank = 2'b01,
      ppo_active = 2'b11,
      ppo_hblank = 2'b10
   } ppo_state_t;
endpackage

// ==== logic/ppo_top.sv ====
// parallel pixel output port with boot strap and apb register access
`timescale 1ns/1ps
`include "ppo_consts.svh"
module ppo_top
   import ppo_pkg::*;
#(
   parameter int boot_cycles = `PPO_BOOT_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic boot_select,
   input wire logic parallel_enable_n,
   input wire logic test_reset_n,
   input wire logic [9:0] raw_sample,
   input wire logic [9:0] proc_sample,
   input wire logic input_reference_clock,
   output logic row_active_flag,
   output logic row_active_flag_oe,
   output logic pixel_active_flag,
   output logic pixel_active_flag_oe,
   output logic pixel_sample_clock,
   output logic pixel_sample_clock_oe,
   output logic [7:0] pixel_bus,
   output logic pixel_bus_oe,
   output logic [1:0] pixel_low_bits,
   output logic pixel_low_bits_oe,
   output logic serial_lane_active
);
   // the boot timer is sixteen bits wide, so longer boots cannot be timed
   if (boot_cycles < 1 || boot_cycles > 65535) begin
      $error("boot_cycles out of range");
   end

   // control registers on the apb side
   logic [4:0] ctrl;
   logic [11:0] hact;
   logic [11:0] hblk;
   logic [11:0] vact;
   logic [11:0] vblk;
   logic [31:0] variable;
   logic [15:0] boot_cnt;
   logic boot_done;
   logic strap_taken;
   logic [1:0] strap_sync;
   logic [1:0] oe_sync;
   logic [1:0] trst_sync;
   logic [1:0] frame_sync;
   logic frame_toggle;

   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == `PPO_ADDR_CTRL) || (a == `PPO_ADDR_STATUS) ||
         (a == `PPO_ADDR_HACT) || (a == `PPO_ADDR_HBLK) ||
         (a == `PPO_ADDR_VACT) || (a == `PPO_ADDR_VBLK) || (a == `PPO_ADDR_VAR);
   endfunction

   // a write lands only at the access edge where ready is seen high;
   // read data is gathered in setup so that it stands through the access
   wire logic apb_wr = psel && penable && pwrite && pready;
   wire logic apb_rd = psel && !penable && !pwrite;
   // last count of the boot timer; the strap is taken there
   wire logic boot_last = (boot_cnt == 16'(boot_cycles - 1));

   // strap, enable and test-reset pins pass two flops before use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_sync <= 2'h0;
         oe_sync <= 2'h3;
         trst_sync <= 2'h0;
      end else begin
         strap_sync <= {strap_sync[0], boot_select};
         oe_sync <= {oe_sync[0], parallel_enable_n};
         trst_sync <= {trst_sync[0], test_reset_n};
      end
   end

   // boot timer; the strap is caught once, after the release, not under reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_cnt <= 16'h0;
         boot_done <= 1'b0;
         strap_taken <= 1'b0;
      end else if (!boot_done) begin
         boot_cnt <= boot_cnt + 16'h1;
         if (boot_last) begin
            boot_done <= 1'b1;
            strap_taken <= strap_sync[1];
         end
      end
   end

   // register writes; host access to controls and a variable word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= 5'h0;
         hact <= `PPO_HACT_RST;
         hblk <= `PPO_HBLK_RST;
         vact <= `PPO_VACT_RST;
         vblk <= `PPO_VBLK_RST;
         variable <= 32'h0;
      end else begin
         // a host write in the boot-end cycle is lost; the strap wins there
         if (boot_last && !boot_done) begin
            ctrl[`PPO_CTRL_STREAM] <= strap_sync[1];
         end else if (apb_wr) begin
            unique case (paddr)
               `PPO_ADDR_CTRL: ctrl <= pwdata[4:0];
               `PPO_ADDR_HACT: hact <= pwdata[11:0];
               `PPO_ADDR_HBLK: hblk <= pwdata[11:0];
               `PPO_ADDR_VACT: vact <= pwdata[11:0];
               `PPO_ADDR_VBLK: vblk <= pwdata[11:0];
               `PPO_ADDR_VAR: variable <= pwdata;
               default: ;
            endcase
         end
      end
   end

   // read data is latched in setup; no wait state, pready is high in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !is_mapped(paddr);
         if (apb_rd) begin
            unique case (paddr)
               `PPO_ADDR_CTRL: prdata <= {27'h0, ctrl};
               `PPO_ADDR_STATUS: prdata <= {27'h0, trst_sync[1], !oe_sync[1],
                  frame_sync[1], strap_taken, boot_done};
               `PPO_ADDR_HACT: prdata <= {20'h0, hact};
               `PPO_ADDR_HBLK: prdata <= {20'h0, hblk};
               `PPO_ADDR_VACT: prdata <= {20'h0, vact};
               `PPO_ADDR_VBLK: prdata <= {20'h0, vblk};
               `PPO_ADDR_VAR: prdata <= variable;
               default: prdata <= 32'h0;
            endcase
         end
      end
   end

   // serial lanes only when selected and the parallel port is off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_lane_active <= 1'b0;
      end else begin
         serial_lane_active <= boot_done && ctrl[`PPO_CTRL_SERIAL] && oe_sync[1];
      end
   end

   // settings into the link domain: levels through two flops; the geometry is
   // only changed while streaming is off, so quasi-static capture suffices
   logic [1:0] lrst_sync;
   logic [1:0] run_sync;
   logic [1:0] en_sync;
   logic [1:0] mode_sync;
   logic [1:0] src_sync;
   logic [1:0] emb_sync;
   logic [11:0] hact_l;
   logic [11:0] hblk_l;
   logic [11:0] vact_l;
   logic [11:0] vblk_l;
   logic [11:0] hcnt;
   logic [11:0] vcnt;
   ppo_state_t state;

   wire logic run_p = boot_done && ctrl[`PPO_CTRL_STREAM];
   // the port may drive only with its enable low and the serial lanes not selected,
   // but its pins switch three link clocks later and the lanes one pclk later, so both can be on briefly
   wire logic en_p = !oe_sync[1] && !ctrl[`PPO_CTRL_SERIAL];

   // bus-side levels into the link domain, two flops each
   always_ff @(posedge input_reference_clock or negedge presetn) begin
      if (!presetn) begin
         lrst_sync <= 2'h0;
         run_sync <= 2'h0;
         en_sync <= 2'h0;
         mode_sync <= 2'h0;
         src_sync <= 2'h0;
         emb_sync <= 2'h0;
      end else begin
         lrst_sync <= {lrst_sync[0], 1'b1};
         run_sync <= {run_sync[0], run_p};
         en_sync <= {en_sync[0], en_p};
         mode_sync <= {mode_sync[0], ctrl[`PPO_CTRL_WIDE]};
         src_sync <= {src_sync[0], ctrl[`PPO_CTRL_RAW]};
         emb_sync <= {emb_sync[0], ctrl[`PPO_CTRL_EMBED]};
      end
   end

   // half-rate pixel step: each pixel stands for two link clocks, which lets a
   // plain flop make a full pixel clock; the cost is half the link rate
   logic pix_phase;
   always_ff @(posedge input_reference_clock or negedge presetn) begin
      if (!presetn) begin
         pix_phase <= 1'b0;
      end else begin
         pix_phase <= !pix_phase;
      end
   end

   // true on the last count of a span of the given length
   function automatic logic at_last(input logic [11:0] cnt, input logic [11:0] len);
      at_last = (cnt == len - 12'h1);
   endfunction

   // frame timing machine on the link clock, moving on step edges only
   always_ff @(posedge input_reference_clock or negedge presetn) begin
      if (!presetn) begin
         state <= ppo_idle;
         hcnt <= 12'h0;
         vcnt <= 12'h0;
         hact_l <= `PPO_HACT_RST;
         hblk_l <= `PPO_HBLK_RST;
         vact_l <= `PPO_VACT_RST;
         vblk_l <= `PPO_VBLK_RST;
      end else if (!pix_phase) begin
         unique case (state)
            ppo_idle: begin
               // geometry is taken only here, so a change needs streaming off
               hact_l <= hact;
               hblk_l <= hblk;
               vact_l <= vact;
               vblk_l <= vblk;
               hcnt <= 12'h0;
               vcnt <= 12'h0;
               if (run_sync[1] && lrst_sync[1]) begin
                  state <= ppo_vblank;
               end
            end
            ppo_vblank: begin
               // vertical blanking lasts one step more than its count
               hcnt <= hcnt + 12'h1;
               if (hcnt >= vblk_l) begin
                  hcnt <= 12'h0;
                  vcnt <= 12'h0;
                  state <= run_sync[1] ? ppo_active : ppo_idle;
               end
            end
            ppo_active: begin
               hcnt <= hcnt + 12'h1;
               if (at_last(hcnt, hact_l)) begin
                  hcnt <= 12'h0;
                  state <= ppo_hblank;
               end
            end
            ppo_hblank: begin
               hcnt <= hcnt + 12'h1;
               if (at_last(hcnt, hblk_l)) begin
                  hcnt <= 12'h0;
                  vcnt <= vcnt + 12'h1;
                  // after the last row the frame falls into vertical blanking
                  state <= at_last(vcnt, vact_l) ? ppo_vblank : ppo_active;
               end
            end
         endcase
      end
   end

   // outputs from flops; undriven while disabled or in reset
   logic [9:0] sample;
   always_comb begin
      sample = src_sync[1] ? raw_sample : proc_sample;
   end

   // qualifiers and pixel data, changed on step edges only
   always_ff @(posedge input_reference_clock or negedge presetn) begin
      if (!presetn) begin
         row_active_flag <= 1'b0;
         pixel_active_flag <= 1'b0;
         pixel_bus <= 8'h0;
         pixel_low_bits <= 2'h0;
      end else if (!pix_phase) begin
         row_active_flag <= (state == ppo_active) || (state == ppo_hblank);
         pixel_active_flag <= (state == ppo_active) && !emb_sync[1];
         if (state == ppo_active) begin
            pixel_bus <= mode_sync[1] ? sample[9:2] : sample[7:0];
            pixel_low_bits <= mode_sync[1] ? sample[1:0] : 2'h0;
         end else begin
            // blanking carries zero data
            pixel_bus <= 8'h0;
            pixel_low_bits <= 2'h0;
         end
      end
   end

   // pin drivers; off in reset and while the port is disabled
   always_ff @(posedge input_reference_clock or negedge presetn) begin
      if (!presetn) begin
         row_active_flag_oe <= 1'b0;
         pixel_active_flag_oe <= 1'b0;
         pixel_sample_clock_oe <= 1'b0;
         pixel_bus_oe <= 1'b0;
         pixel_low_bits_oe <= 1'b0;
      end else begin
         row_active_flag_oe <= en_sync[1];
         pixel_active_flag_oe <= en_sync[1];
         pixel_sample_clock_oe <= en_sync[1];
         pixel_bus_oe <= en_sync[1];
         // the low-bit pair is only driven in 10-bit mode
         pixel_low_bits_oe <= en_sync[1] && mode_sync[1];
      end
   end

   // frame-end marker; a toggle so the bus side needs no handshake back
   always_ff @(posedge input_reference_clock or negedge presetn) begin
      if (!presetn) begin
         frame_toggle <= 1'b0;
      end else if (!pix_phase && state == ppo_hblank && at_last(hcnt, hblk_l) &&
            at_last(vcnt, vact_l)) begin
         frame_toggle <= !frame_toggle;
      end
   end

   // frame-end toggle back into the bus domain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_sync <= 2'h0;
      end else begin
         frame_sync <= {frame_sync[0], frame_toggle};
      end
   end

   // pixel clock from a falling-edge flop: it rises half a link period after
   // the step edge that changes data and flags, and falls a link period later,
   // so the receiver samples on its rise with the data well settled
   always_ff @(negedge input_reference_clock or negedge presetn) begin
      if (!presetn) begin
         pixel_sample_clock <= 1'b0;
      end else begin
         pixel_sample_clock <= pix_phase;
      end
   end
endmodule

// ==== tb/ppo_chk_sva.sv ====
// assertion checker for the parallel pixel output port
`timescale 1ns/1ps
module ppo_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic parallel_enable_n,
   input wire logic input_reference_clock,
   input wire logic row_active_flag,
   input wire logic row_active_flag_oe,
   input wire logic pixel_active_flag,
   input wire logic pixel_active_flag_oe,
   input wire logic pixel_sample_clock_oe,
   input wire logic pixel_bus_oe,
   input wire logic pixel_low_bits_oe,
   input wire logic serial_lane_active
);
   // any pin of the port driven
   wire logic any_oe;
   assign any_oe = row_active_flag_oe | pixel_active_flag_oe | pixel_sample_clock_oe
      | pixel_bus_oe | pixel_low_bits_oe;
   // reset itself is the cause here, so this one has no disable
   reset_undriven_a: assert property (@(posedge pclk) !presetn |-> !any_oe)
      else $error("pins driven during reset");
   pixel_in_row_a: assert property (@(posedge input_reference_clock) disable iff (!presetn)
      pixel_active_flag_oe && pixel_active_flag |-> row_active_flag) else $error("pixel outside row");
   disabled_port_a: assert property (@(posedge pclk) disable iff (!presetn)
      parallel_enable_n [*6] |-> !any_oe) else $error("port driven while disabled");
   one_path_a: assert property (@(posedge pclk) disable iff (!presetn)
      serial_lane_active |-> !pixel_bus_oe) else $error("both paths active");
   low_bits_a: assert property (@(posedge input_reference_clock) disable iff (!presetn)
      pixel_low_bits_oe |-> pixel_bus_oe) else $error("low bits without bus");
   flags_driven_a: assert property (@(posedge input_reference_clock) disable iff (!presetn)
      pixel_bus_oe |-> row_active_flag_oe && pixel_active_flag_oe) else $error("bus without flags");
   apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready) else $error("no ready in access");
   apb_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready) else $error("ready longer than one cycle");
   apb_error_a: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready && psel && penable) else $error("error outside access");
   row_seen_c: cover property (@(posedge input_reference_clock) $rose(row_active_flag));
   err_seen_c: cover property (@(posedge pclk) pslverr);
   serial_seen_c: cover property (@(posedge pclk) serial_lane_active);
endmodule
bind ppo_top ppo_chk u_ppo_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
   .parallel_enable_n, .input_reference_clock, .row_active_flag, .row_active_flag_oe,
   .pixel_active_flag, .pixel_active_flag_oe, .pixel_sample_clock_oe, .pixel_bus_oe,
   .pixel_low_bits_oe, .serial_lane_active);

// ==== tb/ppo_rx.sv ====
// behavioural image receiver at the far end of the port
`timescale 1ns/1ps
module ppo_rx (
   input wire logic clk,
   input wire logic row_active_flag,
   input wire logic row_active_flag_oe,
   input wire logic pixel_active_flag,
   input wire logic [7:0] pixel_bus,
   input wire logic [1:0] pixel_low_bits
);
   int count = 0;
   int run = 0;
   int lines = 0;
   int line_len = 0;
   int rows = 0;
   logic last_row = 1'b0;
   logic [9:0] word = 10'h000;
   wire logic row_on = row_active_flag_oe & row_active_flag;
   // capture only with both qualifiers high; an undriven port is never sampled
   always @(posedge clk) begin
      if (row_on && pixel_active_flag) begin
         run++;
         count++;
         word = {pixel_bus, pixel_low_bits};
      end else if (run > 0) begin
         line_len = run;
         run = 0;
         lines++;
      end
      // frame height is the lines seen until the row flag drops
      if (last_row && !row_on) begin
         rows = lines;
         lines = 0;
      end
      last_row = row_on;
   end
endmodule

// ==== tb/test_parallel_pixel_output_boot_pins.sv ====
// self-checking bench for the parallel pixel output port
`timescale 1ns/1ps
`include "ppo_consts.svh"
module test_parallel_pixel_output_boot_pins;
   logic pclk = 1'b0, input_reference_clock = 1'b0, presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic boot_select = 1'b1, parallel_enable_n = 1'b0, serial_lane_active;
   logic test_reset_n = 1'b0;
   logic [31:0] v;
   logic [9:0] raw_sample = 10'h000, proc_sample = 10'h000, s, e;
   logic row_active_flag, row_active_flag_oe, pixel_active_flag, pixel_active_flag_oe;
   logic pixel_sample_clock, pixel_sample_clock_oe, pixel_bus_oe, pixel_low_bits_oe;
   logic [7:0] pixel_bus;
   logic [1:0] pixel_low_bits;
   int bad_count = 0, total_checks = 0, cycles = 0, n, c0;
   wire logic [4:0] oes = {row_active_flag_oe, pixel_active_flag_oe, pixel_sample_clock_oe,
      pixel_bus_oe, pixel_low_bits_oe};
   always #25 pclk = ~pclk;
   // link clock offset so its edges never line up with pclk
   initial #3 forever #7.5 input_reference_clock = ~input_reference_clock;
   ppo_top #(.boot_cycles(16)) u_ppo_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .boot_select, .parallel_enable_n, .test_reset_n,
      .raw_sample, .proc_sample, .input_reference_clock, .row_active_flag, .row_active_flag_oe,
      .pixel_active_flag, .pixel_active_flag_oe, .pixel_sample_clock, .pixel_sample_clock_oe,
      .pixel_bus, .pixel_bus_oe, .pixel_low_bits, .pixel_low_bits_oe, .serial_lane_active);
   ppo_rx u_ppo_rx (.clk(pixel_sample_clock), .row_active_flag, .row_active_flag_oe,
      .pixel_active_flag, .pixel_bus, .pixel_low_bits);
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // one apb transfer, request held until pready is seen at an edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge, so a following call never drives psel twice in a step
      @(posedge pclk);
   endtask
   // enough captures for two whole frames after a settings change
   task wait_pix;
      c0 = u_ppo_rx.count;
      for (n = 0; n < 3000 && u_ppo_rx.count < c0 + 400; n++) @(posedge pclk);
   endtask
   task reset_dut(input logic strap);
      presetn <= 1'b0;
      boot_select <= strap;
      repeat (8) @(posedge pclk);
      chk("oe in reset", oes, 0);
      presetn <= 1'b1;
      @(posedge pclk);
      rd = 0;
      for (int i = 0; i < 40 && rd[0] !== 1'b1; i++) apb(0, `PPO_ADDR_STATUS, 0);
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test;
      end
   end
   initial begin
      n = $urandom(32'h2a27b8db);
      reset_dut(1'b1);
      apb(0, `PPO_ADDR_CTRL, 0);
      chk("stream bit", rd[0], 1);
      apb(0, `PPO_ADDR_STATUS, 0);
      chk("status", rd & 32'h1b, 32'h0b);
      apb(0, `PPO_ADDR_HBLK, 0);
      chk("hblk", rd, `PPO_HBLK_RST);
      apb(0, `PPO_ADDR_VBLK, 0);
      chk("vblk", rd, `PPO_VBLK_RST);
      apb(0, 12'h01c, 0);
      chk("unmapped", err, 1);
      v = $urandom;
      apb(1, `PPO_ADDR_VAR, v);
      apb(0, `PPO_ADDR_VAR, 0);
      chk("variable", rd, v);
      $display("test registers done");
      // every width and source: m[0] selects 10-bit, m[1] raw source
      for (int m = 0; m < 4; m++) begin
         raw_sample <= 10'($urandom);
         proc_sample <= 10'($urandom);
         apb(1, `PPO_ADDR_CTRL, 32'(m * 2 + 1));
         wait_pix;
         s = m[1] ? raw_sample : proc_sample;
         e = m[0] ? s : {s[7:0], 2'b00};
         chk("pixel", m[0] ? u_ppo_rx.word : {u_ppo_rx.word[9:2], 2'b00}, e);
         chk("line", u_ppo_rx.line_len, `PPO_HACT_RST);
         chk("rows", u_ppo_rx.rows, `PPO_VACT_RST);
      end
      // geometry is taken by the link side only while it idles
      apb(1, `PPO_ADDR_CTRL, 32'h000);
      apb(1, `PPO_ADDR_HACT, 32'h00c);
      repeat (200) @(posedge pclk);
      apb(1, `PPO_ADDR_CTRL, 32'h001);
      wait_pix;
      chk("short line", u_ppo_rx.line_len, 32'h00c);
      // embedded sync: rows still framed, but no pixel qualifier to capture on
      apb(1, `PPO_ADDR_CTRL, 32'h009);
      repeat (10) @(posedge pclk);
      c0 = u_ppo_rx.count;
      repeat (300) @(posedge pclk);
      chk("embedded", u_ppo_rx.count, c0);
      chk("embedded rows", u_ppo_rx.rows, 0);
      $display("test frames done");
      parallel_enable_n <= 1'b1;
      repeat (20) @(posedge pclk);
      chk("oe off", oes, 0);
      apb(0, `PPO_ADDR_STATUS, 0);
      chk("port bit", rd[3], 0);
      // serial path chosen with the port enable held high
      apb(1, `PPO_ADDR_CTRL, 32'h011);
      repeat (20) @(posedge pclk);
      chk("serial", {serial_lane_active, pixel_bus_oe}, 2'b10);
      $display("test enable done");
      parallel_enable_n <= 1'b0;
      reset_dut(1'b0);
      apb(0, `PPO_ADDR_CTRL, 0);
      chk("standby", rd[0], 0);
      c0 = u_ppo_rx.count;
      repeat (400) @(posedge pclk);
      chk("no frames", u_ppo_rx.count, c0);
      $display("test standby done");
      end_of_test;
   end
endmodule
